//--- ssf_pkg.sv
/*
 Constants, offsets and field layouts of the sensor sample FIFO.
 Assumes one system clock for all users of these values.
*/
package ssf_pkg;
    // Buffer geometry
    localparam int          DEPTH      = 32;
    localparam int          SBYTES     = 5;
    localparam int          SW         = 8 * SBYTES;
    localparam logic [5:0]  CNT_FULL   = 6'h20;
    localparam logic [2:0]  BIDX_LAST  = 3'h4;
    // Register addresses
    localparam logic [7:0]  A_PMSB     = 8'h01;
    localparam logic [7:0]  A_OUT_LAST = 8'h05;
    localparam logic [7:0]  A_STATUS   = 8'h0D;
    localparam logic [7:0]  A_PORT     = 8'h0E;
    localparam logic [7:0]  A_SETUP    = 8'h0F;
    localparam logic [7:0]  A_DLY      = 8'h10;
    localparam logic [7:0]  A_STATE    = 8'h11;
    // Setup register fields, reset values and delay limit
    localparam int          MODE_LSB   = 6;
    localparam int          WM_LSB     = 0;
    localparam logic [1:0]  MODE_RST   = 2'h0;
    localparam logic [5:0]  WM_RST     = 6'h00;
    localparam logic [7:0]  DLY_RST    = 8'h00;
    localparam logic [7:0]  DLY_MAX    = 8'hFF;
    // Overflow mode codes
    localparam logic [1:0]  M_OFF      = 2'h0;
    localparam logic [1:0]  M_CIRC     = 2'h1;
    localparam logic [1:0]  M_STOP     = 2'h2;
    // Serial slave states
    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
    } ssf_i2c_st_t;
endpackage

//--- ssf_mem.sv
/*
 Sample storage: one word per sample, one write and one read port.
 Assumes the caller never writes and relies on a read of one slot
 in the same cycle.
*/
`timescale 1ns/1ps
module ssf_mem import ssf_pkg::*; (
    // Clock
    input  wire logic          clk_i,
    // Write side
    input  wire logic          we_i,
    input  wire logic [4:0]    wa_i,
    input  wire logic [SW-1:0] wd_i,
    // Read side
    input  wire logic [4:0]    ra_i,
    output logic      [SW-1:0] rd_o
);
    logic [SW-1:0] mem [DEPTH];

    // Storage needs no reset; the count says what is valid
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[wa_i] <= wd_i;
        end
    end

    // Asynchronous read keeps the byte path one cycle short
    assign rd_o = mem[ra_i];
endmodule

//--- ssf_i2c.sv
/*
 Serial register slave: pin sampling, address match, pointer with
 auto increment, one write strobe per data byte, one read strobe per
 byte fetched. Assumes SCL is far slower than clk_i.
*/
`timescale 1ns/1ps
module ssf_i2c import ssf_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h3A
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_ni,
    // Pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oen_o,
    // Register side
    output logic [7:0]      addr_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       stay_i
);
    typedef struct packed {
        logic        scl1, scl2, sclp;
        logic        sda1, sda2, sdap;
        ssf_i2c_st_t st;
        logic [3:0]  bitc;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic        flag;
        logic        oen;
        logic        wr;
        logic        rd;
        logic [7:0]  wdat;
    } ssf_i2c_t;

    ssf_i2c_t q, d;
    logic     rise, fall, start, stop;

    // Bit engine; enable is low while SDA is pulled low
    always_comb begin
        d = q;
        d.scl1 = scl_i;
        d.scl2 = q.scl1;
        d.sclp = q.scl2;
        d.sda1 = sda_i;
        d.sda2 = q.sda1;
        d.sdap = q.sda2;
        d.wr = 1'b0;
        d.rd = 1'b0;
        rise = q.scl2 & ~q.sclp;
        fall = ~q.scl2 & q.sclp;
        start = q.scl2 & q.sclp & q.sdap & ~q.sda2;
        stop = q.scl2 & q.sclp & ~q.sdap & q.sda2;
        // Pointer moves after the access that used it
        if (q.wr || (q.rd && !stay_i)) begin
            d.ptr = q.ptr + 8'h01;
        end
        if (start) begin
            d.st = I_ADDR;
            d.bitc = 4'h0;
            d.oen = 1'b1;
        end else if (stop) begin
            d.st = I_IDLE;
            d.oen = 1'b1;
        end else begin
            unique case (q.st)
                I_IDLE: ;
                I_ADDR, I_WR: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], q.sda2};
                        d.bitc = q.bitc + 4'h1;
                    end else if (fall && q.bitc == 4'h8) begin
                        d.oen = 1'b0;
                        if (q.st == I_WR) begin
                            d.st = I_WACK;
                            d.flag = 1'b0;
                            if (q.flag) begin
                                d.ptr = q.sh;
                            end else begin
                                d.wr = 1'b1;
                                d.wdat = q.sh;
                            end
                        end else if (q.sh[7:1] == DEV_ADDR) begin
                            d.st = I_AACK;
                        end else begin
                            d.st = I_IDLE;
                            d.oen = 1'b1;
                        end
                    end
                end
                I_AACK, I_WACK: begin
                    if (fall) begin
                        d.oen = 1'b1;
                        d.bitc = 4'h0;
                        d.st = I_WR;
                        if (q.st == I_AACK && q.sh[0]) begin
                            d.st = I_RD;
                            d.sh = rdata_i;
                            d.oen = rdata_i[7];
                            d.rd = 1'b1;
                        end else if (q.st == I_AACK) begin
                            d.flag = 1'b1; // First byte is the pointer
                        end
                    end
                end
                I_RD: begin
                    if (rise) begin
                        d.bitc = q.bitc + 4'h1;
                    end else if (fall && q.bitc == 4'h8) begin
                        d.oen = 1'b1;
                        d.st = I_RACK;
                    end else if (fall) begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oen = q.sh[6];
                    end
                end
                I_RACK: begin
                    if (rise) begin
                        d.flag = q.sda2; // High means no more bytes
                    end else if (fall && q.flag) begin
                        d.st = I_IDLE;
                    end else if (fall) begin
                        d.st = I_RD;
                        d.bitc = 4'h0;
                        d.sh = rdata_i;
                        d.oen = rdata_i[7];
                        d.rd = 1'b1;
                    end
                end
            endcase
        end
    end

    // Idle bus levels at reset keep false starts away
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            q <= '{scl1: 1'b1, scl2: 1'b1, sclp: 1'b1,
                   sda1: 1'b1, sda2: 1'b1, sdap: 1'b1,
                   st: I_IDLE, oen: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oen_o = q.oen;
    assign addr_o = q.ptr;
    assign wr_o = q.wr;
    assign wdata_o = q.wdat;
    assign rd_o = q.rd;
endmodule

//--- ssf_top.sv
/*
 Sensor sample FIFO: 32 five-byte samples, overflow modes, flags,
 tick delay counter and mode indication, reached over the serial
 register slave. Assumes sample_i, sample_data_i, live_data_i and
 active_i come from logic on clk_i; SCL and SDA are async pins.
*/
//
// Contract
// RULE1 - Hold up to 32 samples of five bytes, 160 bytes at most.
// RULE2 - The data port is read only; writes leave the buffer alone.
// RULE3 - With a mode other than disabled, address 0x01 reads buffer data.
// RULE4 - With the buffer on, addresses 0x02 to 0x05 read zero.
// RULE5 - Samples keep entering while the host reads buffer data.
// RULE6 - Bytes come out pressure high to temperature low; empty reads zero.
// RULE7 - Reads take the oldest sample; count drops once per sample.
// RULE8 - The host drains the buffer with one burst read.
// RULE9 - Passing the watermark never stops sample intake.
// RULE10 - Samples enter at the acquisition tick rate.
// RULE11 - Mode 00 off, 01 circular, 10 stop on full, 11 unused.
// RULE12 - Stop mode refuses samples when full until data is read.
// RULE13 - Flush on disable or standby to active; disable clears flags.
// RULE14 - Overflow flag rises when the count reaches 32.
// RULE15 - Watermark flag at count equal watermark; zero disables it.
// RULE16 - Host writes disabled before switching circular and stop.
// RULE17 - No direct change between circular and stop codes.
// RULE18 - Mode field is writable in active operation.
// RULE19 - Watermark field is writable in standby.
// RULE20 - Delay counts ticks after overflow, clears on last read.
// RULE21 - Mode register: bit 0 active, bits 7-1 zero, reset zero.
// RULE22 - Flags follow their condition; status read clears event.
// RULE23 - Six-bit count gives stored samples, 0 to 32.
// RULE24 - Code 11 behaves as disabled and takes no samples; the code reads 0x01 to 0x05 as zero for it, not the live data.
`timescale 1ns/1ps
module ssf_top import ssf_pkg::*; #(
    parameter logic [6:0] I2C_ADDR = 7'h3A // Arbitrary value
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    // Serial pins
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oen_o,
    // Acquisition side
    input  wire logic          sample_i,
    input  wire logic [SW-1:0] sample_data_i,
    input  wire logic [SW-1:0] live_data_i,
    input  wire logic          active_i,
    // Flags and sample count
    output logic               overflow_flag_o,
    output logic               watermark_flag_o,
    output logic               fifo_event_o,
    output logic [5:0]         sample_count_o
);
    typedef struct packed {
        logic [1:0] mode;
        logic [5:0] wm;
        logic [4:0] wp;
        logic [4:0] rp;
        logic [5:0] cnt;
        logic [2:0] bidx;
        logic [7:0] dly;
        logic       run;
        logic       ovf;
        logic       wmf;
        logic       evt;
        logic       act;
    } ssf_st_t;

    ssf_st_t         q, d;
    logic [1:0]      rs_q;
    logic            rst_n;
    logic [7:0]      addr, wdata, rdata;
    logic            wr, rd, stay;
    logic [SW-1:0]   mem_rd, shifted, live_sh;
    logic            en, sel, pop, done, full, acc, drop, flush;
    logic [1:0]      nm;

    // Reset released through two flip-flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    ssf_i2c #(.DEV_ADDR(I2C_ADDR)) u_i2c (
        .clk_i     (clk_i),
        .rst_ni    (rst_n),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oen_o (sda_oen_o),
        .addr_o    (addr),
        .wr_o      (wr),
        .wdata_o   (wdata),
        .rd_o      (rd),
        .rdata_i   (rdata),
        .stay_i    (stay)
    );

    ssf_mem u_mem (
        .clk_i (clk_i),
        .we_i  (acc),
        .wa_i  (q.wp),
        .wd_i  (sample_data_i),
        .ra_i  (q.rp),
        .rd_o  (mem_rd)
    );

    // Buffer control, setup writes, flags and delay counter
    always_comb begin
        d = q;
        d.act = active_i;
        en = (q.mode == M_CIRC) || (q.mode == M_STOP); // RULE11 RULE24
        sel = (addr == A_PORT) || (addr == A_PMSB && q.mode != M_OFF);
        stay = sel; // RULE8
        full = (q.cnt == CNT_FULL);
        pop = rd && sel && (q.cnt != 6'h00); // RULE5
        done = pop && (q.bidx == BIDX_LAST);
        acc = sample_i && en && (!full || q.mode == M_CIRC); // RULE10 RULE9 RULE12
        drop = acc && full && !done; // RULE11
        flush = !en || (active_i && !q.act); // RULE13
        nm = wdata[MODE_LSB +: 2];
        // Mode writes between the two running codes are dropped
        if (wr && addr == A_SETUP) begin
            if (!((q.mode == M_CIRC && nm == M_STOP) ||
                  (q.mode == M_STOP && nm == M_CIRC))) begin
                d.mode = nm; // RULE17 RULE18
            end
            if (!q.act) begin
                d.wm = wdata[WM_LSB +: 6]; // RULE19
            end
        end
        // Byte walk through the oldest sample
        if (pop) begin
            d.bidx = done ? 3'h0 : q.bidx + 3'h1; // RULE6
        end
        // Overwrite restarts the byte walk on the new oldest sample
        if (drop) begin
            d.bidx = 3'h0;
        end
        if (acc) begin
            d.wp = q.wp + 5'h01;
        end
        if (done || drop) begin
            d.rp = q.rp + 5'h01; // RULE7
        end
        d.cnt = q.cnt + 6'((acc && !drop) ? 1 : 0)
                - 6'(done ? 1 : 0); // RULE7 RULE23
        // Delay runs from overflow until the last byte leaves
        if (d.cnt == CNT_FULL) begin
            d.run = 1'b1; // RULE20
        end
        if (q.run && sample_i && q.dly != DLY_MAX) begin
            d.dly = q.dly + 8'h01; // RULE20
        end
        if (done && d.cnt == 6'h00) begin
            d.run = 1'b0;
            d.dly = DLY_RST; // RULE20
        end
        if (flush) begin
            d.wp = 5'h00;
            d.rp = 5'h00;
            d.cnt = 6'h00;
            d.bidx = 3'h0;
            d.run = 1'b0;
            d.dly = DLY_RST;
        end
        d.ovf = (d.cnt == CNT_FULL); // RULE14 RULE22
        d.wmf = (q.wm != 6'h00) && (d.cnt >= q.wm); // RULE15 RULE22
        // Event set wins over the clear from a status read
        if (rd && addr == A_STATUS) begin
            d.evt = 1'b0; // RULE22
        end
        if ((d.ovf && !q.ovf) || (d.cnt == q.wm && d.wmf && !q.wmf)) begin
            d.evt = 1'b1; // RULE22
        end
    end

    // Read data seen by the slave when it fetches a byte
    always_comb begin
        shifted = mem_rd << {q.bidx, 3'b000};
        live_sh = live_data_i << {addr[2:0] - 3'h1, 3'b000};
        rdata = 8'h00;
        if (sel) begin
            rdata = (q.cnt != 6'h00) ? shifted[SW-1 -: 8] : 8'h00; // RULE3
        end else if (addr >= A_PMSB && addr <= A_OUT_LAST) begin
            rdata = (q.mode != M_OFF) ? 8'h00 : live_sh[SW-1 -: 8]; // RULE4
        end else if (addr == A_STATUS) begin
            rdata = {q.ovf, q.wmf, q.cnt};
        end else if (addr == A_SETUP) begin
            rdata = {q.mode, q.wm};
        end else if (addr == A_DLY) begin
            rdata = q.dly;
        end else if (addr == A_STATE) begin
            rdata = {7'h00, q.act}; // RULE21
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{mode: MODE_RST, wm: WM_RST, dly: DLY_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    assign overflow_flag_o = q.ovf;
    assign watermark_flag_o = q.wmf;
    assign fifo_event_o = q.evt;
    assign sample_count_o = q.cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    count_bound_a: assert property (q.cnt <= CNT_FULL) // RULE1
        else $error("sample count above capacity");
    port_ro_a: assert property (wr && addr == A_PORT && !acc && !pop
        && !flush |=> $stable(q.cnt) && $stable(q.wp)) // RULE2
        else $error("write to data port changed buffer");
    alias_zero_a: assert property (q.mode != M_OFF && addr > A_PMSB
        && addr <= A_OUT_LAST |-> rdata == 8'h00) // RULE4
        else $error("aliased output address not zero");
    empty_zero_a: assert property (sel && q.cnt == 6'h00
        |-> rdata == 8'h00) // RULE6
        else $error("empty buffer read not zero");
    pop_count_a: assert property (done && !acc && !flush
        |=> q.cnt == $past(q.cnt) - 6'h01) // RULE7
        else $error("sample consume did not drop count");
    stop_full_a: assert property (q.mode == M_STOP && full && sample_i
        && !rd && !flush |=> q.cnt == CNT_FULL && $stable(q.wp)) // RULE12
        else $error("stop mode accepted a sample when full");
    off_clear_a: assert property (q.mode == M_OFF
        |=> q.cnt == 6'h00 && !q.ovf && !q.wmf) // RULE13
        else $error("disabled buffer kept state");
    ovf_rise_a: assert property ($rose(q.cnt == CNT_FULL)
        |-> q.ovf) // RULE14
        else $error("overflow flag missing at full");
    wm_off_a: assert property (q.wm == 6'h00 |-> !q.wmf) // RULE15
        else $error("watermark flag with zero watermark");
    no_swap_a: assert property (q.mode == M_CIRC
        |=> q.mode != M_STOP) // RULE17
        else $error("direct circular to stop change");
    state_read_a: assert property (addr == A_STATE
        |-> rdata == {7'h00, q.act}) // RULE21
        else $error("mode register read wrong");
    evt_hold_a: assert property ($rose(q.ovf) |-> q.evt) // RULE22
        else $error("overflow did not raise the event");

    circ_wrap_c: cover property (q.mode == M_CIRC && drop);
    full_read_c: cover property (done && q.cnt == CNT_FULL);
    wm_hit_c: cover property ($rose(q.wmf));
    dly_run_c: cover property (q.run && q.dly == 8'h03);
endmodule

//--- ssf_host.sv
/*
 Host model: bus master that drives SCL and pulls SDA low when needed.
 Assumes an open-drain SDA with a pull-up and a slave clocked by clk_i.
*/
`timescale 1ns/1ps
module ssf_host #(
    parameter logic [6:0] ADDR = 7'h3A
) (
    input  wire logic clk_i,
    input  wire logic dev_sda_i,
    input  wire logic dev_oen_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic       low_q;
    logic [7:0] rq[$];
    int         nak;
    // Pull-up wins unless some party drives the line low
    assign sda_o = ~(low_q | (~dev_oen_i & ~dev_sda_i));
    initial begin
        scl_o = 1'b1;
        low_q = 1'b0;
        nak   = 0;
    end
    // Change pins just after an edge, then keep them for n cycles
    task automatic hold(input logic c, input logic l, input int n);
        @(posedge clk_i);
        scl_o <= c;
        low_q <= l;
        repeat (n - 1) @(posedge clk_i);
    endtask
    // SCL falls before SDA moves, so no false START or STOP is seen
    task automatic bit_io(input logic b, output logic r);
        hold(1'b0, low_q, 2);
        hold(1'b0, ~b, 2);
        hold(1'b1, ~b, 2);
        @(negedge clk_i);
        r = sda_o;
        hold(1'b1, ~b, 2);
    endtask
    // One byte plus the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic last,
                        input logic wr, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(last, r);
        if (wr && r !== 1'b0) begin
            nak++;
        end
    endtask
    // Also serves as repeated START
    task automatic start();
        hold(1'b0, low_q, 2);
        hold(1'b0, 1'b0, 2);
        hold(1'b1, 1'b0, 4);
        hold(1'b1, 1'b1, 4);
        hold(1'b0, 1'b1, 2);
    endtask
    task automatic stop();
        hold(1'b0, low_q, 2);
        hold(1'b0, 1'b1, 2);
        hold(1'b1, 1'b1, 4);
        hold(1'b1, 1'b0, 4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({ADDR, 1'b0}, 1'b1, 1'b1, q);
        xfer(a, 1'b1, 1'b1, q);
        xfer(d, 1'b1, 1'b1, q);
        stop();
    endtask
    // Burst read: ACK every byte but the last, which gets NACK
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] q;
        rq.delete();
        start();
        xfer({ADDR, 1'b0}, 1'b1, 1'b1, q);
        xfer(a, 1'b1, 1'b1, q);
        start();
        xfer({ADDR, 1'b1}, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, i == n - 1, 1'b0, q);
            rq.push_back(q);
        end
        stop();
    endtask
endmodule

//--- sensor_sample_fifo_test.sv
/*
 Testbench of the sample FIFO: register traffic through the host model,
 samples and mode driven here. Assumes the default serial address.
*/
`timescale 1ns/1ps
module sensor_sample_fifo_test import ssf_pkg::*;;
    localparam logic [6:0] DEV = 7'h3A; // Arbitrary bus address
    logic          clk_i;
    logic          resetn_i;
    logic          sample_i;
    logic [SW-1:0] sample_data_i;
    logic [SW-1:0] live_data_i;
    logic          active_i;
    logic          scl;
    logic          sda;
    logic          sda_o;
    logic          sda_oen_o;
    logic          ovf;
    logic          wmf;
    logic          evt;
    logic [5:0]    cnt;
    logic [1:0]    md;
    logic [7:0]    nk;
    logic [7:0]    d1;
    logic [SW-1:0] exp_q[$];
    int            n_fail = 0;
    int            checked = 0;

    ssf_top #(.I2C_ADDR(DEV)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oen_o(sda_oen_o), .sample_i(sample_i),
        .sample_data_i(sample_data_i), .live_data_i(live_data_i),
        .active_i(active_i), .overflow_flag_o(ovf),
        .watermark_flag_o(wmf), .fifo_event_o(evt), .sample_count_o(cnt)
    );
    ssf_host #(.ADDR(DEV)) u_host (
        .clk_i(clk_i), .dev_sda_i(sda_o), .dev_oen_i(sda_oen_o),
        .scl_o(scl), .sda_o(sda)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic results();
        $display("Checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Distinct bytes per position so a wrong order shows up
    function automatic logic [SW-1:0] smp(input logic [7:0] k);
        return {k, k + 8'h55, k + 8'hAA, ~k, k ^ 8'h3C};
    endfunction

    // One tick; the expected queue follows the overflow mode
    task automatic push();
        @(posedge clk_i);
        sample_i      <= 1'b1;
        sample_data_i <= smp(nk);
        if (md == M_CIRC && exp_q.size() == DEPTH) begin
            exp_q.delete(0);
        end
        if (md == M_CIRC || (md == M_STOP && exp_q.size() < DEPTH)) begin
            exp_q.push_back(smp(nk));
        end
        nk++;
        @(posedge clk_i);
        sample_i <= 1'b0;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, 1);
        chk($sformatf("reg %h", a), u_host.rq[0], e);
    endtask

    // Burst of n bytes from the aliased data address
    task automatic drain(input int n);
        u_host.rd(A_PMSB, n);
        for (int i = 0; i < n; i++) begin
            if (exp_q.size() == 0) begin
                chk("data", u_host.rq[i], 8'h00);
            end else begin
                chk("data", u_host.rq[i], exp_q[0][SW-1-8*(i%5) -: 8]);
                if (i % 5 == 4) begin
                    exp_q.delete(0);
                end
            end
        end
        repeat (2) @(negedge clk_i);
    endtask

    // Cut a hang short well past the expected run length
    initial begin
        #2_500_000;
        n_fail++;
        results();
    end

    initial begin
        resetn_i      = 1'b0;
        sample_i      = 1'b0;
        sample_data_i = '0;
        live_data_i   = 40'h11_22_33_44_55;
        active_i      = 1'b0;
        md            = M_OFF;
        nk            = 8'h00;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reg_is(A_STATE, 8'h00);
        reg_is(A_DLY, 8'h00);
        reg_is(A_SETUP, 8'h00);
        // Disabled buffer leaves the live registers in place
        u_host.rd(A_PMSB, 5);
        for (int j = 0; j < 5; j++) begin
            chk("live", u_host.rq[j], live_data_i[SW-1-8*j -: 8]);
        end
        u_host.wr(A_SETUP, 8'h43);
        reg_is(A_SETUP, 8'h43);
        @(posedge clk_i);
        active_i <= 1'b1;
        md       <= M_CIRC;
        repeat (4) @(posedge clk_i);
        reg_is(A_STATE, 8'h01);
        repeat (3) push();
        chk("count", {2'b0, cnt}, 8'h03);
        chk("wm flag", {7'b0, wmf}, 8'h01);
        chk("event", {7'b0, evt}, 8'h01);
        reg_is(A_STATUS, 8'h43);
        chk("event", {7'b0, evt}, 8'h00);
        u_host.wr(A_SETUP, 8'h45);
        reg_is(A_SETUP, 8'h43);
        u_host.wr(A_PORT, 8'h55);
        chk("count", {2'b0, cnt}, 8'h03);
        for (logic [7:0] a = 8'h02; a <= A_OUT_LAST; a++) begin
            reg_is(a, 8'h00);
        end
        // Intake continues while a burst read is under way
        fork
            drain(5);
            begin
                repeat (200) @(posedge clk_i);
                push();
            end
        join
        chk("count", {2'b0, cnt}, 8'h03);
        while (exp_q.size() < DEPTH) push();
        chk("count", {2'b0, cnt}, 8'h20);
        chk("ovf", {7'b0, ovf}, 8'h01);
        u_host.rd(A_DLY, 1);
        d1 = u_host.rq[0];
        repeat (2) push();
        reg_is(A_DLY, d1 + 8'h02);
        drain(5);
        u_host.wr(A_SETUP, 8'h83);
        reg_is(A_SETUP, 8'h43);
        u_host.wr(A_SETUP, 8'h03);
        md = M_OFF;
        exp_q.delete();
        chk("count", {2'b0, cnt}, 8'h00);
        chk("ovf", {7'b0, ovf}, 8'h00);
        chk("wm flag", {7'b0, wmf}, 8'h00);
        // Stop mode with the watermark switched off
        @(posedge clk_i);
        active_i <= 1'b0;
        u_host.wr(A_SETUP, 8'h80);
        @(posedge clk_i);
        active_i <= 1'b1;
        md       <= M_STOP;
        repeat (4) @(posedge clk_i);
        repeat (DEPTH + 1) push();
        chk("count", {2'b0, cnt}, 8'h20);
        chk("wm flag", {7'b0, wmf}, 8'h00);
        drain(161);
        chk("count", {2'b0, cnt}, 8'h00);
        reg_is(A_DLY, 8'h00);
        // Standby to active flushes stored samples
        repeat (2) push();
        @(posedge clk_i);
        active_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        active_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk("count", {2'b0, cnt}, 8'h00);
        exp_q.delete();
        u_host.wr(A_SETUP, 8'hC0);
        reg_is(A_SETUP, 8'hC0);
        md = M_OFF;
        push();
        chk("count", {2'b0, cnt}, 8'h00);
        chk("acks", 8'(u_host.nak), 8'h00);
        results();
    end
endmodule
